// ==== include/gdc_consts.svh ====
/*
  Constants of the grayscale converter control block: serial word layout,
  control codes and converter preset values.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef GDC_CONSTS_SVH
`define GDC_CONSTS_SVH

`define GDC_WORD_BITS     16
`define GDC_CNT_W         5
`define GDC_CODE_MSB      15
`define GDC_CODE_LSB      12
`define GDC_DATA_MSB      11
`define GDC_DATA_LSB      2
`define GDC_DATA_W        10
`define GDC_UPPER_PRESET  10'h3af
`define GDC_LOWER_PRESET  10'h028
`define GDC_CODE_NOP      4'h0
`define GDC_CODE_LD_A     4'h1
`define GDC_CODE_LD_B     4'h2
`define GDC_CODE_XFER     4'h8
`define GDC_CODE_LDX_A    4'h9
`define GDC_CODE_LDX_B    4'ha
`define GDC_CODE_WAKE     4'hd
`define GDC_CODE_SLEEP    4'he
`define GDC_CODE_LDX_AB   4'hf

`endif

// ==== include/gdc_pkg.sv ====
/*
  Types of the grayscale converter control block.
  Assumes the constants header sits on the include path.
*/
`include "gdc_consts.svh"

package gdc_pkg;
  typedef logic [`GDC_DATA_W-1:0] gdc_code_t;
  typedef logic [3:0]             gdc_ctrl_t;
  // Serial receiver states, Gray coded along idle, shift, full
  typedef enum logic [1:0] {
    GDC_IDLE  = 2'b00,
    GDC_SHIFT = 2'b01,
    GDC_FULL  = 2'b11
  } gdc_rx_state_t;
endpackage

// ==== hdl/gdc_sync.sv ====
/*
  Two-flip-flop synchroniser for one asynchronous pin.
  Assumes a single core clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps

module gdc_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic rst_val,
  input  wire logic pin_in,
  output logic      sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // Next values: first stage samples the pin, second reads only the first
  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  // Reset to the idle level given by the constant tie-off
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q ^ rst_val;
endmodule

// ==== hdl/gdc_serial_rx.sv ====
/*
  Serial word receiver: shifts the data pin on rising serial clock edges
  while the load select is low and flags a valid word on its rising edge.
  Assumes synchronised inputs; serial clock well below half the core clock.
*/
`timescale 1ns/10ps
`include "gdc_consts.svh"

module gdc_serial_rx (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    sel_n,
  input  wire logic                    sck,
  input  wire logic                    din,
  output logic                         word_valid,
  output logic [`GDC_WORD_BITS-1:0]    word
);
  gdc_pkg::gdc_rx_state_t        st_q, st_d;
  logic [`GDC_WORD_BITS-1:0]     sh_q, sh_d;
  logic [`GDC_CNT_W-1:0]         cnt_q, cnt_d;
  logic                          sck_q, sck_d;
  logic                          vld_q, vld_d;
  logic                          sel_q, sel_d;

  // Shift control; early rise of select discards the word
  always_comb begin
    st_d  = st_q;
    sh_d  = sh_q;
    cnt_d = cnt_q;
    vld_d = 1'b0;
    sck_d = sck;
    sel_d = sel_n;
    case (st_q)
      gdc_pkg::GDC_IDLE: begin
        if (!sel_n && sel_q) begin
          cnt_d = '0;
          sh_d  = '0;
          st_d  = gdc_pkg::GDC_SHIFT;
        end
      end
      gdc_pkg::GDC_SHIFT: begin
        if (sel_n) begin
          sh_d = '0;
          st_d = gdc_pkg::GDC_IDLE;
        end else if (sck && !sck_q) begin
          sh_d  = {sh_q[`GDC_WORD_BITS-2:0], din};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(`GDC_WORD_BITS - 1)) begin
            st_d = gdc_pkg::GDC_FULL;
          end
        end
      end
      gdc_pkg::GDC_FULL: begin
        if (sel_n) begin
          vld_d = 1'b1;
          st_d  = gdc_pkg::GDC_IDLE;
        end
      end
      default: st_d = gdc_pkg::GDC_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= gdc_pkg::GDC_IDLE;
      sh_q  <= '0;
      cnt_q <= '0;
      sck_q <= 1'b0;
      vld_q <= 1'b0;
      sel_q <= 1'b1;
    end else begin
      st_q  <= st_d;
      sh_q  <= sh_d;
      cnt_q <= cnt_d;
      sck_q <= sck_d;
      vld_q <= vld_d;
      sel_q <= sel_d;
    end
  end

  assign word_valid = vld_q;
  assign word       = sh_q;
endmodule

// ==== hdl/gdc_power_ctrl.sv ====
/*
  Control logic of a grayscale reference generator: double-buffered
  converter registers, sleep state, shutdown arbitration and common
  electrode / tap-4 switch selection.
  Assumes a host drives the serial port and static pins asynchronously;
  power-on reset is rst_n. All outputs are registered.
*/
`timescale 1ns/10ps
`include "gdc_consts.svh"

// Contract
// - Valid completed write loads addressed input register
// - Control code moves inputs to converter registers
// - Power-on presets upper 3af, lower 028
// - Power-on state is awake
// - Low pin or sleep gives full shutdown
// - Serial logic keeps running during shutdown
// - Waking uses last accepted register contents
// - Registers and sleep state are retained
// - Both group inputs high disable mid buffers
// - Pin low and sleep override group inputs
// - Electrode selection always active
// - Mode high selects supply by polarity
// - Tap-4 switch high: open, buffer on
// - Word is four code, ten data, two spare
// - Load and transfer codes as tabulated
// - Sleep, wake and no-operation codes
// - Early select rise discards the word
module gdc_power_ctrl (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   load_select_n,
  input  wire logic                   serial_clk,
  input  wire logic                   serial_data,
  input  wire logic                   power_shutdown_n,
  input  wire logic                   mid_buffer_off_a,
  input  wire logic                   mid_buffer_off_b,
  input  wire logic                   electrode_mode_select,
  input  wire logic                   polarity_invert,
  input  wire logic                   tap4_switch_n,
  output logic [`GDC_DATA_W-1:0]      upper_dac_code,
  output logic [`GDC_DATA_W-1:0]      lower_dac_code,
  output logic                        sleep_state,
  output logic                        full_shutdown,
  output logic                        end_buffers_oe_n,
  output logic                        mid_buffers_oe_n,
  output logic                        tap4_buffer_oe_n,
  output logic                        tap4_output_to_com,
  output logic                        com_sel_external,
  output logic                        com_sel_supply,
  output logic                        com_sel_ground
);
  logic                   sel_s;
  logic                   sck_s;
  logic                   din_s;
  logic                   psk_s;
  logic                   gsa_s;
  logic                   gsb_s;
  logic                   cm_s;
  logic                   pol_s;
  logic                   cv4_s;
  logic                   word_valid;
  logic [`GDC_WORD_BITS-1:0] word;
  gdc_pkg::gdc_ctrl_t     code;
  gdc_pkg::gdc_code_t     data;

  gdc_pkg::gdc_code_t     in_a_q, in_a_d;
  gdc_pkg::gdc_code_t     in_b_q, in_b_d;
  gdc_pkg::gdc_code_t     dac_a_q, dac_a_d;
  gdc_pkg::gdc_code_t     dac_b_q, dac_b_d;
  logic                   sleep_q, sleep_d;

  logic                   full_q, full_d;
  logic                   end_oe_n_q, end_oe_n_d;
  logic                   mid_oe_n_q, mid_oe_n_d;
  logic                   t4_oe_n_q, t4_oe_n_d;
  logic                   t4_com_q, t4_com_d;
  logic                   c_ext_q, c_ext_d;
  logic                   c_sup_q, c_sup_d;
  logic                   c_gnd_q, c_gnd_d;

  // Pin synchronisers; select and shutdown pin idle high, others idle low,
  // so no false shutdown pulse follows the release of reset
  gdc_sync u_sync_sel (.core_clk(core_clk), .rst_n(rst_n), .rst_val(1'b1),
                       .pin_in(~load_select_n), .sync_out(sel_s));
  gdc_sync u_sync_sck (.core_clk(core_clk), .rst_n(rst_n), .rst_val(1'b0),
                       .pin_in(serial_clk), .sync_out(sck_s));
  gdc_sync u_sync_din (.core_clk(core_clk), .rst_n(rst_n), .rst_val(1'b0),
                       .pin_in(serial_data), .sync_out(din_s));
  gdc_sync u_sync_psk (.core_clk(core_clk), .rst_n(rst_n), .rst_val(1'b1),
                       .pin_in(~power_shutdown_n), .sync_out(psk_s));
  gdc_sync u_sync_gsa (.core_clk(core_clk), .rst_n(rst_n), .rst_val(1'b0),
                       .pin_in(mid_buffer_off_a), .sync_out(gsa_s));
  gdc_sync u_sync_gsb (.core_clk(core_clk), .rst_n(rst_n), .rst_val(1'b0),
                       .pin_in(mid_buffer_off_b), .sync_out(gsb_s));
  gdc_sync u_sync_cm  (.core_clk(core_clk), .rst_n(rst_n), .rst_val(1'b0),
                       .pin_in(electrode_mode_select), .sync_out(cm_s));
  gdc_sync u_sync_pol (.core_clk(core_clk), .rst_n(rst_n), .rst_val(1'b0),
                       .pin_in(polarity_invert), .sync_out(pol_s));
  gdc_sync u_sync_cv4 (.core_clk(core_clk), .rst_n(rst_n), .rst_val(1'b0),
                       .pin_in(tap4_switch_n), .sync_out(cv4_s));

  // Serial receiver runs whatever the power state
  gdc_serial_rx u_rx (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .sel_n      (sel_s),
    .sck        (sck_s),
    .din        (din_s),
    .word_valid (word_valid),
    .word       (word)
  );

  // Word fields: code on top, data next, two spare bits ignored
  assign code = word[`GDC_CODE_MSB:`GDC_CODE_LSB];
  assign data = word[`GDC_DATA_MSB:`GDC_DATA_LSB];

  // Command decode into input registers, converter registers and sleep
  always_comb begin
    in_a_d  = in_a_q;
    in_b_d  = in_b_q;
    dac_a_d = dac_a_q;
    dac_b_d = dac_b_q;
    sleep_d = sleep_q;
    if (word_valid) begin
      case (code)
        `GDC_CODE_LD_A: in_a_d = data;
        `GDC_CODE_LD_B: in_b_d = data;
        `GDC_CODE_XFER: begin
          dac_a_d = in_a_q;
          dac_b_d = in_b_q;
          sleep_d = 1'b0;
        end
        `GDC_CODE_LDX_A: begin
          in_a_d  = data;
          dac_a_d = data;
          dac_b_d = in_b_q;
          sleep_d = 1'b0;
        end
        `GDC_CODE_LDX_B: begin
          in_b_d  = data;
          dac_a_d = in_a_q;
          dac_b_d = data;
          sleep_d = 1'b0;
        end
        `GDC_CODE_LDX_AB: begin
          in_a_d  = data;
          in_b_d  = data;
          dac_a_d = data;
          dac_b_d = data;
          sleep_d = 1'b0;
        end
        `GDC_CODE_WAKE:  sleep_d = 1'b0;
        `GDC_CODE_SLEEP: sleep_d = 1'b1;
        default: sleep_d = sleep_q;
      endcase
    end
  end

  // Stored converter state; converters keep codes loaded while asleep
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_a_q  <= `GDC_UPPER_PRESET;
      in_b_q  <= `GDC_LOWER_PRESET;
      dac_a_q <= `GDC_UPPER_PRESET;
      dac_b_q <= `GDC_LOWER_PRESET;
      sleep_q <= 1'b0;
    end else begin
      in_a_q  <= in_a_d;
      in_b_q  <= in_b_d;
      dac_a_q <= dac_a_d;
      dac_b_q <= dac_b_d;
      sleep_q <= sleep_d;
    end
  end

  // Shutdown arbitration and electrode switch selection
  always_comb begin
    full_d     = !psk_s || sleep_q;
    end_oe_n_d = full_d;
    mid_oe_n_d = full_d || (gsa_s && gsb_s);
    t4_com_d   = !cv4_s;
    t4_oe_n_d  = full_d || !cv4_s;
    c_ext_d    = !cm_s;
    c_sup_d    = cm_s && pol_s;
    c_gnd_d    = cm_s && !pol_s;
  end

  // Output selection registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      full_q     <= 1'b0;
      end_oe_n_q <= 1'b0;
      mid_oe_n_q <= 1'b0;
      t4_oe_n_q  <= 1'b1;
      t4_com_q   <= 1'b1;
      c_ext_q    <= 1'b1;
      c_sup_q    <= 1'b0;
      c_gnd_q    <= 1'b0;
    end else begin
      full_q     <= full_d;
      end_oe_n_q <= end_oe_n_d;
      mid_oe_n_q <= mid_oe_n_d;
      t4_oe_n_q  <= t4_oe_n_d;
      t4_com_q   <= t4_com_d;
      c_ext_q    <= c_ext_d;
      c_sup_q    <= c_sup_d;
      c_gnd_q    <= c_gnd_d;
    end
  end

  assign upper_dac_code     = dac_a_q;
  assign lower_dac_code     = dac_b_q;
  assign sleep_state        = sleep_q;
  assign full_shutdown      = full_q;
  assign end_buffers_oe_n   = end_oe_n_q;
  assign mid_buffers_oe_n   = mid_oe_n_q;
  assign tap4_buffer_oe_n   = t4_oe_n_q;
  assign tap4_output_to_com = t4_com_q;
  assign com_sel_external   = c_ext_q;
  assign com_sel_supply     = c_sup_q;
  assign com_sel_ground     = c_gnd_q;
endmodule

// ==== verif/gdc_power_ctrl_monitor.sv ====
/*
  Port checker for the converter control block.
  Assumes binding to gdc_power_ctrl; one core clock, active-low reset.
*/
`timescale 1ns/10ps
`include "gdc_consts.svh"

module gdc_power_ctrl_monitor (
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  input wire logic                   load_select_n,
  input wire logic                   power_shutdown_n,
  input wire logic                   mid_buffer_off_a,
  input wire logic                   mid_buffer_off_b,
  input wire logic                   electrode_mode_select,
  input wire logic                   polarity_invert,
  input wire logic                   tap4_switch_n,
  input wire logic [`GDC_DATA_W-1:0] upper_dac_code,
  input wire logic [`GDC_DATA_W-1:0] lower_dac_code,
  input wire logic                   sleep_state,
  input wire logic                   full_shutdown,
  input wire logic                   end_buffers_oe_n,
  input wire logic                   mid_buffers_oe_n,
  input wire logic                   tap4_buffer_oe_n,
  input wire logic                   tap4_output_to_com,
  input wire logic                   com_sel_external,
  input wire logic                   com_sel_supply,
  input wire logic                   com_sel_ground
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Presets and awake state right after power-on
  a_preset_codes_seen: assert property ($rose(rst_n) |-> upper_dac_code == `GDC_UPPER_PRESET
    && lower_dac_code == `GDC_LOWER_PRESET && !sleep_state)
    else $error("preset codes or sleep flag wrong after reset");
  // Converter codes only move after a completed frame
  a_codes_hold_low: assert property ((!load_select_n)[*6] |-> $stable(upper_dac_code)
    && $stable(lower_dac_code))
    else $error("converter code moved while select held low");
  // Shutdown arbitration
  a_pin_full_off: assert property ((!power_shutdown_n)[*4] |-> full_shutdown)
    else $error("low shutdown pin did not force full shutdown");
  a_sleep_full_off: assert property (sleep_state && $past(sleep_state) |-> full_shutdown)
    else $error("sleep flag did not force full shutdown");
  a_full_all_off: assert property (full_shutdown |-> end_buffers_oe_n && mid_buffers_oe_n
    && tap4_buffer_oe_n)
    else $error("buffer left driving in full shutdown");
  a_mid_group_off: assert property ((mid_buffer_off_a && mid_buffer_off_b)[*4]
    ##0 !full_shutdown |-> mid_buffers_oe_n)
    else $error("middle buffers driving with both group inputs high");
  a_mid_group_on: assert property ((power_shutdown_n && !(mid_buffer_off_a
    && mid_buffer_off_b))[*4] ##0 !full_shutdown |-> !mid_buffers_oe_n)
    else $error("middle buffers off without both group inputs high");
  // Common electrode and tap-4 switch selection
  a_com_one_source: assert property ($onehot({com_sel_external, com_sel_supply,
    com_sel_ground}))
    else $error("common source select not one-hot");
  a_com_mode_ext: assert property ((!electrode_mode_select)[*4] |-> com_sel_external)
    else $error("common not from external input with mode low");
  a_com_by_pol: assert property ((electrode_mode_select && polarity_invert)[*4]
    |-> com_sel_supply)
    else $error("common not on supply with mode and polarity high");
  a_tap4_closed: assert property ((!tap4_switch_n)[*4] |-> tap4_output_to_com
    && tap4_buffer_oe_n)
    else $error("tap-4 switch low but output not on common");
  a_tap4_open: assert property (tap4_switch_n[*4] ##0 !full_shutdown
    |-> !tap4_output_to_com && !tap4_buffer_oe_n)
    else $error("tap-4 switch high but buffer not driving");

  // Main scenarios reached
  c_sleep: cover property ($rose(sleep_state));
  c_mid_off: cover property (!full_shutdown && mid_buffers_oe_n);
  c_code_move: cover property ($changed(upper_dac_code));
endmodule

bind gdc_power_ctrl gdc_power_ctrl_monitor u_gdc_power_ctrl_monitor (
  .core_clk(core_clk), .rst_n(rst_n), .load_select_n(load_select_n),
  .power_shutdown_n(power_shutdown_n), .mid_buffer_off_a(mid_buffer_off_a),
  .mid_buffer_off_b(mid_buffer_off_b), .electrode_mode_select(electrode_mode_select),
  .polarity_invert(polarity_invert), .tap4_switch_n(tap4_switch_n),
  .upper_dac_code(upper_dac_code), .lower_dac_code(lower_dac_code),
  .sleep_state(sleep_state), .full_shutdown(full_shutdown),
  .end_buffers_oe_n(end_buffers_oe_n), .mid_buffers_oe_n(mid_buffers_oe_n),
  .tap4_buffer_oe_n(tap4_buffer_oe_n), .tap4_output_to_com(tap4_output_to_com),
  .com_sel_external(com_sel_external), .com_sel_supply(com_sel_supply),
  .com_sel_ground(com_sel_ground));

// ==== verif/gdc_host_model.sv ====
/*
  Host model driving the three-wire serial port of the control block.
  Assumes the core clock paces it; serial clock half periods of 4 cycles.
*/
`timescale 1ns/10ps

module gdc_host_model (
  input  wire logic core_clk,
  output logic      load_select_n,
  output logic      serial_clk,
  output logic      serial_data
);
  // Idle port: select high, clock parked low
  initial begin
    load_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_data = 1'b0;
  end

  // Sends nbits of a word MSB first; beyond 16 the bits are filler
  task automatic send(input logic [15:0] w, input int nbits);
    @(posedge core_clk) load_select_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < nbits; i++) begin
      serial_data <= (i < 16) ? w[15-i] : ~serial_data;
      repeat (4) @(posedge core_clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    load_select_n <= 1'b1;
    serial_data <= ~serial_data;
  endtask
endmodule

// ==== verif/gdc_power_ctrl_tb_top.sv ====
/*
  Self-checking bench of the converter control block.
  Assumes the host model file and the port checker are compiled first.
*/
`timescale 1ns/10ps
`include "gdc_consts.svh"

module gdc_power_ctrl_tb_top;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       power_shutdown_n = 1'b1;
  logic       mid_buffer_off_a = 1'b1;
  logic       mid_buffer_off_b = 1'b1;
  logic       electrode_mode_select = 1'b1;
  logic       polarity_invert = 1'b0;
  logic       tap4_switch_n = 1'b0;
  logic       load_select_n, serial_clk, serial_data;
  logic [9:0] upper_dac_code, lower_dac_code;
  logic       sleep_state, full_shutdown, end_buffers_oe_n, mid_buffers_oe_n;
  logic       tap4_buffer_oe_n, tap4_output_to_com;
  logic       com_sel_external, com_sel_supply, com_sel_ground;
  logic [9:0] up_e = `GDC_UPPER_PRESET, lo_e = `GDC_LOWER_PRESET;
  logic [9:0] ina_e = `GDC_UPPER_PRESET, inb_e = `GDC_LOWER_PRESET;
  logic       slp_e = 1'b0;
  int         miscompares = 0;
  int         check_count = 0;
  logic [15:0] dir [12] = '{16'he000, 16'h1ffc, 16'h2004, 16'hd000, 16'he000, 16'h8000,
                            16'h9abc, 16'ha554, 16'hf000, 16'h0ffc, 16'hb3fc, 16'h7ffc};

  always #5 core_clk = ~core_clk;

  gdc_host_model u_gdc_host_model (.core_clk(core_clk), .load_select_n(load_select_n),
    .serial_clk(serial_clk), .serial_data(serial_data));

  gdc_power_ctrl u_gdc_power_ctrl (.core_clk(core_clk), .rst_n(rst_n),
    .load_select_n(load_select_n), .serial_clk(serial_clk), .serial_data(serial_data),
    .power_shutdown_n(power_shutdown_n), .mid_buffer_off_a(mid_buffer_off_a),
    .mid_buffer_off_b(mid_buffer_off_b), .electrode_mode_select(electrode_mode_select),
    .polarity_invert(polarity_invert), .tap4_switch_n(tap4_switch_n),
    .upper_dac_code(upper_dac_code), .lower_dac_code(lower_dac_code),
    .sleep_state(sleep_state), .full_shutdown(full_shutdown),
    .end_buffers_oe_n(end_buffers_oe_n), .mid_buffers_oe_n(mid_buffers_oe_n),
    .tap4_buffer_oe_n(tap4_buffer_oe_n), .tap4_output_to_com(tap4_output_to_com),
    .com_sel_external(com_sel_external), .com_sel_supply(com_sel_supply),
    .com_sel_ground(com_sel_ground));

  // Compares one value and reports a mismatch
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected register and sleep effect of one accepted word
  task automatic apply(input logic [15:0] w);
    logic [3:0] c;
    c = w[15:12];
    if (c == 4'h1 || c == 4'h9 || c == 4'hf) ina_e = w[11:2];
    if (c == 4'h2 || c == 4'ha || c == 4'hf) inb_e = w[11:2];
    if (c[3] && (c <= 4'ha || c == 4'hf)) begin
      up_e = ina_e;
      lo_e = inb_e;
      slp_e = 1'b0;
    end
    if (c == 4'hd) slp_e = 1'b0;
    if (c == 4'he) slp_e = 1'b1;
  endtask

  // Checks every output against the expected state and pins
  task automatic check_all();
    logic       fsd;
    logic [2:0] com_exp;
    fsd = !power_shutdown_n || slp_e;
    com_exp = {!electrode_mode_select, electrode_mode_select && polarity_invert,
               electrode_mode_select && !polarity_invert};
    chk(upper_dac_code, up_e);
    chk(lower_dac_code, lo_e);
    chk(sleep_state, slp_e);
    chk(full_shutdown, fsd);
    chk(end_buffers_oe_n, fsd);
    chk(mid_buffers_oe_n, fsd || (mid_buffer_off_a && mid_buffer_off_b));
    chk(tap4_buffer_oe_n, fsd || !tap4_switch_n);
    chk(tap4_output_to_com, !tap4_switch_n);
    chk({com_sel_external, com_sel_supply, com_sel_ground}, com_exp);
  endtask

  // Sends one frame, updates expectations if complete, then checks
  task automatic frame(input logic [15:0] w, input int nbits);
    u_gdc_host_model.send(w, nbits);
    if (nbits >= 16) apply(w);
    repeat (10) @(posedge core_clk);
    check_all();
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence: presets, directed codes, abort, overlong, random
  initial begin
    void'($urandom(32'h6ace));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    check_all();
    foreach (dir[i]) frame(dir[i], 16);
    frame(16'hf3fc, 15);
    frame(16'h9ab4, 18);
    repeat (60) begin
      @(posedge core_clk);
      {power_shutdown_n, mid_buffer_off_a, mid_buffer_off_b, electrode_mode_select,
       polarity_invert, tap4_switch_n} <= 6'($urandom);
      frame(16'($urandom), 16);
    end
    print_verdict();
  end

  // Hang guard well beyond the expected run length
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
endmodule
